// ### hdl/psm_protection_standby_monitor.sv
// Protection and standby logic: undervoltage flags, thermal state, standby.
//
// Contract
// - Any gate-supply undervoltage turns all MOSFETs off and drops the flag.
// - Flag and MOSFETs stay off during undervoltage; status read releases the flag after, bridge release command the MOSFETs.
// - Threshold select bit chooses low (0) or high (1) comparator set.
// - ADC-input undervoltage drops its flag until recovery plus status read.
// - ADC-input undervoltage never turns off the bridge MOSFETs.
// - Normal thermal operation reports state 00.
// - Warning reports 01, no restriction, until warning release.
// - Bridge shutdown reports 10, MOSFETs off, drivers off, clamps on.
// - Device shutdown reports 11, clamps on, regulators and pump off, logic limited.
// - Control logic stays active in device shutdown until its release.
// - Standby low: MOSFETs high impedance, pump stopped, interface off, logic limited.
// - Standby returns all registers to defaults and disables protections.
// - Leaving standby keeps MOSFETs off with the high-impedance flag set.
// - Register default command restores defaults without entering standby.
// - Fault pin pulls low for unmasked undervoltage and thermal alarms.
`timescale 1ns/10ps
module psm_protection_standby_monitor #(
  parameter int unsigned STBY_MIN_CYC = psm_pkg::STBY_MIN_CYC
) (
  input  wire logic              clock,
  input  wire logic              arst_n,
  input  wire logic              standbyReset_n,
  input  wire psm_pkg::psm_cmp_t cmpLow,
  input  wire psm_pkg::psm_cmp_t cmpHigh,
  input  wire logic              statusReadClearCommand,
  input  wire logic              registerDefaultCommand,
  input  wire logic              bridgeReleaseCommand,
  input  wire logic [psm_pkg::MASK_W-1:0] alarmMaskIn,
  input  wire logic              alarmMaskWrite,
  input  wire logic              thresholdSelectIn,
  input  wire logic              thresholdSelectWrite,
  output logic                   supplyUndervoltageFlag_n,
  output logic                   adcInputUndervoltageFlag_n,
  output logic [1:0]             thermalStateField,
  output logic                   bridgesHighImpedanceFlag,
  output logic                   undervoltageThresholdSelect,
  output psm_pkg::psm_power_t    powerCtrl,
  output logic                   interfaceEnable,
  output logic                   standbyActive,
  output logic                   faultOut,
  output logic                   faultOe
);

  initial begin
    if (STBY_MIN_CYC < 1 || STBY_MIN_CYC > 65535) begin
      $error("STBY_MIN_CYC out of range");
    end
  end

  // Two-stage synchronisers; the first stage feeds only the second.
  psm_pkg::psm_cmp_t lowS1_r, lowS2_r, highS1_r, highS2_r;
  logic              stbyS1_r, stbyS2_r;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lowS1_r  <= '0;
      lowS2_r  <= '0;
      highS1_r <= '0;
      highS2_r <= '0;
      stbyS1_r <= 1'b0;
      stbyS2_r <= 1'b0;
    end else begin
      lowS1_r  <= cmpLow;
      lowS2_r  <= lowS1_r;
      highS1_r <= cmpHigh;
      highS2_r <= highS1_r;
      stbyS1_r <= standbyReset_n;
      stbyS2_r <= stbyS1_r;
    end
  end

  logic     standby;
  assign standby = ~stbyS2_r;

  logic              selR;
  psm_pkg::psm_cmp_t cmp;
  always_comb begin
    cmp = selR ? highS2_r : lowS2_r;
  end

  logic       supplyUnder;
  assign supplyUnder = cmp.lowSideUnder | cmp.highSideUnder;

  logic [psm_pkg::MASK_W-1:0] maskR, maskNxt;
  logic       selNxt;
  logic       uvFlagR, uvFlagNxt, adcFlagR, adcFlagNxt;
  logic       hizR, hizNxt;
  logic [1:0] thR, thNxt;
  logic [15:0] stbyCntR, stbyCntNxt;
  logic       defaults;

  // Standby and the default command share one path back to reset values.
  assign defaults = standby | registerDefaultCommand;

  always_comb begin
    maskNxt    = maskR;
    selNxt     = selR;
    uvFlagNxt  = uvFlagR;
    adcFlagNxt = adcFlagR;
    hizNxt     = hizR;
    thNxt      = thR;
    stbyCntNxt = stbyCntR;
    if (standby && stbyCntR != 16'hFFFF) begin
      stbyCntNxt = stbyCntR + 16'h0001;
    end else if (!standby) begin
      stbyCntNxt = 16'h0000;
    end
    if (alarmMaskWrite) begin
      maskNxt = alarmMaskIn;
    end
    if (thresholdSelectWrite) begin
      selNxt = thresholdSelectIn;
    end
    // Clear only once the condition is gone, so a live event always wins.
    if (statusReadClearCommand && !supplyUnder) begin
      uvFlagNxt = 1'b1;
    end
    if (statusReadClearCommand && !cmp.adcUnder) begin
      adcFlagNxt = 1'b1;
    end
    if (supplyUnder) begin
      uvFlagNxt = 1'b0;
    end
    if (cmp.adcUnder) begin
      adcFlagNxt = 1'b0;
    end
    if (bridgeReleaseCommand && !supplyUnder
        && thR < psm_pkg::TH_BRIDGEOFF) begin
      hizNxt = 1'b0;
    end
    if (supplyUnder || thR >= psm_pkg::TH_BRIDGEOFF) begin
      hizNxt = 1'b1;
    end
    // Thermal state tracks the highest active comparator.
    if (cmp.deviceHot) begin
      thNxt = psm_pkg::TH_DEVICEOFF;
    end else if (cmp.bridgeHot) begin
      thNxt = psm_pkg::TH_BRIDGEOFF;
    end else if (cmp.warnHot) begin
      thNxt = psm_pkg::TH_WARNING;
    end else begin
      thNxt = psm_pkg::TH_NORMAL;
    end
    if (defaults) begin
      maskNxt    = psm_pkg::MASK_RESET;
      selNxt     = 1'b0;
      uvFlagNxt  = 1'b1;
      adcFlagNxt = 1'b1;
      hizNxt     = 1'b1;
      thNxt      = psm_pkg::TH_NORMAL;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      maskR    <= psm_pkg::MASK_RESET;
      selR     <= 1'b0;
      uvFlagR  <= 1'b1;
      adcFlagR <= 1'b1;
      hizR     <= 1'b1;
      thR      <= psm_pkg::TH_NORMAL;
      stbyCntR <= 16'h0000;
    end else begin
      maskR    <= maskNxt;
      selR     <= selNxt;
      uvFlagR  <= uvFlagNxt;
      adcFlagR <= adcFlagNxt;
      hizR     <= hizNxt;
      thR      <= thNxt;
      stbyCntR <= stbyCntNxt;
    end
  end

  // Output stage, all registered.
  psm_pkg::psm_power_t powerNxt;
  logic                faultNxt;
  always_comb begin
    powerNxt.bridgesOff    = hizNxt;
    powerNxt.gateDriversEn = thNxt < psm_pkg::TH_BRIDGEOFF;
    powerNxt.millerClampEn = 1'b1;
    powerNxt.gateRegEn     = thNxt != psm_pkg::TH_DEVICEOFF;
    powerNxt.chargePumpEn  = thNxt != psm_pkg::TH_DEVICEOFF;
    powerNxt.logicRegLimit = thNxt == psm_pkg::TH_DEVICEOFF;
    faultNxt = (maskNxt[psm_pkg::MASK_UV] & ~uvFlagNxt)
             | (maskNxt[psm_pkg::MASK_ADCUV] & ~adcFlagNxt)
             | (maskNxt[psm_pkg::MASK_TWRN] & (thNxt == psm_pkg::TH_WARNING))
             | (maskNxt[psm_pkg::MASK_TSD] & thNxt[1]);
    if (standby) begin
      powerNxt.bridgesOff    = 1'b1;
      powerNxt.gateDriversEn = 1'b0;
      powerNxt.millerClampEn = 1'b0;
      powerNxt.gateRegEn     = 1'b1;
      powerNxt.chargePumpEn  = 1'b0;
      powerNxt.logicRegLimit = 1'b1;
      faultNxt               = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      supplyUndervoltageFlag_n    <= 1'b1;
      adcInputUndervoltageFlag_n  <= 1'b1;
      thermalStateField           <= psm_pkg::TH_NORMAL;
      bridgesHighImpedanceFlag    <= 1'b1;
      undervoltageThresholdSelect <= 1'b0;
      powerCtrl                   <= '{bridgesOff: 1'b1, gateDriversEn: 1'b0,
                                       millerClampEn: 1'b0, gateRegEn: 1'b1,
                                       chargePumpEn: 1'b0, logicRegLimit: 1'b1};
      interfaceEnable             <= 1'b0;
      standbyActive               <= 1'b1;
      faultOut                    <= 1'b0;
      faultOe                     <= 1'b0;
    end else begin
      supplyUndervoltageFlag_n    <= uvFlagNxt;
      adcInputUndervoltageFlag_n  <= adcFlagNxt;
      thermalStateField           <= thNxt;
      bridgesHighImpedanceFlag    <= hizNxt;
      undervoltageThresholdSelect <= selNxt;
      powerCtrl                   <= powerNxt;
      interfaceEnable             <= ~standby;
      standbyActive               <= standby &&
                                     stbyCntR >= 16'(STBY_MIN_CYC - 1);
      faultOut                    <= 1'b0;
      faultOe                     <= faultNxt;
    end
  end

  // Checks.
  uv_lockout_a: assert property (@(posedge clock) disable iff (!arst_n)
    supplyUnder && !defaults
    |=> !supplyUndervoltageFlag_n && powerCtrl.bridgesOff)
    else $error("undervoltage did not lock out");
  uv_hold_a: assert property (@(posedge clock) disable iff (!arst_n)
    !supplyUndervoltageFlag_n && !defaults && $past(supplyUnder) && supplyUnder
    |=> !supplyUndervoltageFlag_n)
    else $error("undervoltage flag released early");
  adc_flag_a: assert property (@(posedge clock) disable iff (!arst_n)
    cmp.adcUnder && !defaults |=> !adcInputUndervoltageFlag_n)
    else $error("adc flag not dropped");
  adc_nooff_a: assert property (@(posedge clock) disable iff (!arst_n)
    cmp.adcUnder && !supplyUnder && !defaults && !hizR
    && thR < psm_pkg::TH_BRIDGEOFF
    && !cmp.bridgeHot && !cmp.deviceHot |=> !powerCtrl.bridgesOff)
    else $error("adc undervoltage turned bridges off");
  therm_dev_a: assert property (@(posedge clock) disable iff (!arst_n)
    cmp.deviceHot && !defaults
    |=> thermalStateField == psm_pkg::TH_DEVICEOFF
    && !powerCtrl.chargePumpEn && !powerCtrl.gateRegEn)
    else $error("device shutdown not applied");
  therm_br_a: assert property (@(posedge clock) disable iff (!arst_n)
    cmp.bridgeHot && !cmp.deviceHot && !defaults
    |=> thermalStateField == psm_pkg::TH_BRIDGEOFF
    && powerCtrl.millerClampEn && !powerCtrl.gateDriversEn)
    else $error("bridge shutdown not applied");
  stby_off_a: assert property (@(posedge clock) disable iff (!arst_n)
    standby |=> !interfaceEnable && powerCtrl.bridgesOff && !faultOe)
    else $error("standby not applied");
  stby_exit_a: assert property (@(posedge clock) disable iff (!arst_n)
    $fell(standby) |-> bridgesHighImpedanceFlag)
    else $error("bridges not high impedance after standby");
  fault_mask_a: assert property (@(posedge clock) disable iff (!arst_n)
    !standby && !maskNxt[psm_pkg::MASK_UV] && !maskNxt[psm_pkg::MASK_ADCUV]
    && !maskNxt[psm_pkg::MASK_TWRN] && !maskNxt[psm_pkg::MASK_TSD]
    |=> !faultOe)
    else $error("masked alarm drove fault pin");
  c_uv: cover property (@(posedge clock) disable iff (!arst_n)
    !supplyUndervoltageFlag_n ##1 supplyUndervoltageFlag_n);
  c_dev: cover property (@(posedge clock) disable iff (!arst_n)
    thermalStateField == psm_pkg::TH_DEVICEOFF);
  c_stby: cover property (@(posedge clock) disable iff (!arst_n)
    standby ##1 !standby);

endmodule

// ### hdl/psm_pkg.sv
// Package of constants and carrier types for the protection and standby monitor.
package psm_pkg;

  localparam logic [1:0] TH_NORMAL   = 2'h0;
  localparam logic [1:0] TH_WARNING  = 2'h1;
  localparam logic [1:0] TH_BRIDGEOFF = 2'h2;
  localparam logic [1:0] TH_DEVICEOFF = 2'h3;

  localparam int unsigned CLOCK_HZ      = 20_000_000;
  localparam int unsigned STBY_MIN_NS   = 1_000;
  localparam int unsigned STBY_MIN_CYC  =
    ((STBY_MIN_NS * (CLOCK_HZ / 1_000_000)) + 999) / 1_000;

  // Alarm mask bit positions.
  localparam int unsigned MASK_UV    = 0;
  localparam int unsigned MASK_ADCUV = 1;
  localparam int unsigned MASK_TWRN  = 2;
  localparam int unsigned MASK_TSD   = 3;
  localparam int unsigned MASK_W     = 4;

  localparam logic [MASK_W-1:0] MASK_RESET = 4'hF;

  typedef struct packed {
    logic lowSideUnder;
    logic highSideUnder;
    logic adcUnder;
    logic warnHot;
    logic bridgeHot;
    logic deviceHot;
  } psm_cmp_t;

  typedef struct packed {
    logic bridgesOff;
    logic gateDriversEn;
    logic millerClampEn;
    logic gateRegEn;
    logic chargePumpEn;
    logic logicRegLimit;
  } psm_power_t;

endpackage

// ### dv/psm_host_model.sv
// Host controller model driving standby and the command pulses.
`timescale 1ns/10ps
module psm_host_model #(
  parameter int unsigned HOLD_CYC  = 10,
  parameter int unsigned START_CYC = 6
) (
  input  wire logic clock,
  input  wire logic arst_n,
  input  wire logic reqStatus,
  input  wire logic reqDefault,
  input  wire logic reqStandby,
  output logic      standbyReset_n,
  output logic      statusReadClearCommand,
  output logic      registerDefaultCommand
);
  int unsigned lowCnt;
  int unsigned upCnt;

  // Status and default requests that arrive during startup are dropped, as a real host would; standby requests are not.
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lowCnt                 <= 0;
      upCnt                  <= 0;
      standbyReset_n         <= 1'h1;
      statusReadClearCommand <= 1'h0;
      registerDefaultCommand <= 1'h0;
    end else begin
      statusReadClearCommand <= 1'h0;
      registerDefaultCommand <= 1'h0;
      if (lowCnt != 0) begin
        lowCnt         <= lowCnt - 1;
        standbyReset_n <= (lowCnt == 1);
        upCnt          <= 0;
      end else if (reqStandby) begin
        lowCnt         <= HOLD_CYC + 1;
        standbyReset_n <= 1'h0;
      end else if (upCnt < START_CYC) begin
        upCnt <= upCnt + 1;
      end else begin
        statusReadClearCommand <= reqStatus;
        registerDefaultCommand <= reqDefault;
      end
    end
  end
endmodule

// ### dv/tb.sv
// Self-checking bench for the protection and standby monitor.
`timescale 1ns/10ps
module tb;
  logic                clock = 1'h0;
  logic                arst_n = 1'h0;
  psm_pkg::psm_cmp_t   cL = '0;
  psm_pkg::psm_cmp_t   cH = '0;
  logic                rqS = 1'h0;
  logic                rqD = 1'h0;
  logic                rqB = 1'h0;
  logic                brRel = 1'h0;
  logic [3:0]          mIn = 4'hF;
  logic                mWr = 1'h0;
  logic                tIn = 1'h0;
  logic                tWr = 1'h0;
  logic                sby_n, sClr, dCmd, uv_n, adc_n, bridges_high_impedance_flag, sel;
  logic                ifEn, sAct, fOut, fOe;
  logic [1:0]          th;
  psm_pkg::psm_power_t pw;
  int                  mismatches = 0;
  int                  check_count = 0;

  always #25 clock = ~clock;

  psm_host_model i_host (.clock(clock), .arst_n(arst_n), .reqStatus(rqS),
    .reqDefault(rqD), .reqStandby(rqB), .standbyReset_n(sby_n),
    .statusReadClearCommand(sClr), .registerDefaultCommand(dCmd));

  // A short standby minimum keeps the standby scenario brief.
  psm_protection_standby_monitor #(.STBY_MIN_CYC(2)) i_dut (
    .clock(clock), .arst_n(arst_n), .standbyReset_n(sby_n), .cmpLow(cL),
    .cmpHigh(cH), .statusReadClearCommand(sClr),
    .registerDefaultCommand(dCmd), .bridgeReleaseCommand(brRel),
    .alarmMaskIn(mIn), .alarmMaskWrite(mWr), .thresholdSelectIn(tIn),
    .thresholdSelectWrite(tWr), .supplyUndervoltageFlag_n(uv_n),
    .adcInputUndervoltageFlag_n(adc_n), .thermalStateField(th),
    .bridgesHighImpedanceFlag(bridges_high_impedance_flag), .undervoltageThresholdSelect(sel),
    .powerCtrl(pw), .interfaceEnable(ifEn), .standbyActive(sAct),
    .faultOut(fOut), .faultOe(fOe));

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #5;
  endtask

  task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] %s expected %0h seen %0h", nm, e, s);
    end
  endtask

  task automatic host(input logic s, input logic d);
    rqS = s;
    rqD = d;
    step(1);
    rqS = 1'h0;
    rqD = 1'h0;
    step(3);
  endtask

  task automatic cfg(input logic [3:0] m, input logic t);
    mIn = m;
    tIn = t;
    mWr = 1'h1;
    tWr = 1'h1;
    step(1);
    mWr = 1'h0;
    tWr = 1'h0;
    step(1);
  endtask

  task automatic t_uv();
    cL.lowSideUnder = 1'h1;
    step(4);
    chk("uvSet", {uv_n, pw.bridgesOff}, 2'h1);
    chk("uvFault", {fOe, fOut}, 2'h2);
    host(1'h1, 1'h0);
    chk("uvHeld", uv_n, 1'h0);
    cL.lowSideUnder = 1'h0;
    step(4);
    chk("uvLatched", uv_n, 1'h0);
    host(1'h1, 1'h0);
    chk("uvClear", uv_n, 1'h1);
    $display("t_uv done");
  endtask

  task automatic t_thresh();
    cfg(4'hF, 1'h1);
    cL.lowSideUnder = 1'h1;
    step(4);
    chk("selLowIgnored", {sel, uv_n}, 2'h3);
    cH.highSideUnder = 1'h1;
    step(4);
    chk("selHighUsed", uv_n, 1'h0);
    cL = '0;
    cH = '0;
    step(4);
    host(1'h1, 1'h0);
    $display("t_thresh done");
  endtask

  task automatic t_adc();
    brRel = 1'h1;
    step(1);
    brRel = 1'h0;
    step(1);
    chk("released", {bridges_high_impedance_flag, pw.bridgesOff}, 2'h0);
    cL.adcUnder = 1'h1;
    cH.adcUnder = 1'h1;
    step(4);
    chk("adcSet", {adc_n, pw.bridgesOff}, 2'h0);
    host(1'h1, 1'h0);
    chk("adcHeld", adc_n, 1'h0);
    cL = '0;
    cH = '0;
    step(4);
    host(1'h1, 1'h0);
    chk("adcClear", adc_n, 1'h1);
    $display("t_adc done");
  endtask

  task automatic t_therm();
    for (int i = 0; i < 5; i++) begin
      cL.warnHot = (i == 1);
      cL.bridgeHot = (i == 2);
      cL.deviceHot = (i == 3);
      cH = cL;
      step(4);
      chk("thState", th, (i % 4));
      if (i == 1)
        chk("warnRun", {pw.bridgesOff, fOe}, 2'h1);
      if (i == 2)
        chk("brOff", {pw.bridgesOff, pw.gateDriversEn,
                      pw.millerClampEn}, 3'h5);
      if (i == 3)
        chk("devOff", {pw.gateRegEn, pw.chargePumpEn, pw.logicRegLimit,
                       ifEn}, 4'h3);
    end
    $display("t_therm done");
  endtask

  task automatic t_mask();
    cfg(4'h0, 1'h0);
    cL.lowSideUnder = 1'h1;
    step(4);
    chk("maskedUv", {uv_n, fOe}, 2'h0);
    cL.lowSideUnder = 1'h0;
    step(4);
    host(1'h1, 1'h1);
    chk("defNoSby", {sAct, ifEn, uv_n}, 3'h3);
    cL.lowSideUnder = 1'h1;
    step(4);
    chk("defMask", fOe, 1'h1);
    cL.lowSideUnder = 1'h0;
    step(4);
    host(1'h1, 1'h0);
    $display("t_mask done");
  endtask

  task automatic t_standby();
    rqB = 1'h1;
    step(1);
    rqB = 1'h0;
    cL.lowSideUnder = 1'h1;
    step(7);
    chk("sbyLogic", {sAct, ifEn}, 2'h2);
    chk("sbyPwr", {pw.bridgesOff, pw.chargePumpEn}, 2'h2);
    chk("sbyProt", {uv_n, fOe}, 2'h2);
    cL.lowSideUnder = 1'h0;
    step(20);
    chk("exitHiz", {bridges_high_impedance_flag, pw.bridgesOff, sAct}, 3'h6);
    $display("t_standby done");
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Guards against a hang; the whole run needs far fewer cycles.
  initial begin
    repeat (3000) @(posedge clock);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    step(10);
    arst_n = 1'h1;
    step(10);
    t_uv();
    t_thresh();
    t_adc();
    t_therm();
    t_mask();
    t_standby();
    tally_and_finish();
  end
endmodule
